// ==== core/scd_decoder.sv ====
// Command decoder with bank state, burst column generator and power state tracking.
// How it works
// - Commands decode from select, row and column strobes and write select at the rising edge; select high deselects.
// - Deselect starts nothing new; a running burst keeps going.
// - No-operation registers nothing and leaves running work alone.
// - Mode load captures the address bits into the register chosen by bank selects.
// - Row strobe low alone activates: bank selects pick bank, address picks row.
// - Column strobe low alone is a column command; write select picks read or write.
// - Each burst moves the programmed length: 1, 2, 4, 8 or a page.
// - Burst columns wrap in an aligned block, sequential or interleaved.
// - Page bursts are sequential only and run until another command ends them.
// - A new read or write to an open bank restarts the burst at full length from its address.
// - Column commands take bank from selects, column from low ten address bits.
// - Auto close precharges the row when a fixed-length burst runs to its end; otherwise it stays open.
// - Write words with mask high are dropped; mask low words are stored.
// - Row strobe and write select low precharge; bank usable a period later.
// - Auto close bit low closes the selected bank, high closes every bank.
// - Precharge to an idle or already closing bank does nothing.
// - Power down asked during a burst becomes clock suspend instead.
// - One-edge-earlier clock enable gates decoding; it and the current level steer power state entry and exit.
`timescale 1ns/1ps
module scd_decoder
  import scd_pkg::*;
#(
  parameter int PRECHARGE_CYCLES = PRE_CYCLES_DEF
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              cke,
  input  wire logic              cs_n,
  input  wire logic              ras_n,
  input  wire logic              cas_n,
  input  wire logic              we_n,
  input  wire logic              dqm,
  input  wire logic              bank_select_low,
  input  wire logic              bank_select_high,
  input  wire logic [ROW_W-1:0]  addr,
  output      logic [3:0]        cmd_seen_ff,
  output      logic [12:0]       mode_reg_ff,
  output      logic [12:0]       ext_mode_reg_ff,
  output      logic [BANK_N-1:0] bank_open,
  output      logic [BANK_N-1:0] bank_precharging,
  output      logic              burst_busy,
  output      logic              access_valid_ff,
  output      logic              access_write_ff,
  output      logic              access_store_ff,
  output      logic [1:0]        access_bank_ff,
  output      logic [COL_W-1:0]  access_col_ff,
  output      logic [ROW_W-1:0]  access_row_ff,
  output      logic              clock_suspend_ff,
  output      logic              power_down_ff,
  output      logic              deep_power_down_ff
);

  logic             cke_prev_ff;
  scd_cmd_t         cmd;
  logic [1:0]       sel_bank;
  logic             auto_close;
  logic [9:0]       cur_mask;
  logic             cur_page;
  logic             cur_ilv;
  logic             col_go;
  logic             stop_now;
  logic             beat_last;
  logic             step;
  logic             auto_end;
  logic [1:0]       end_bank;
  logic             quiet;
  logic             all_idle;
  logic [BANK_N-1:0] bank_ready;
  logic [BANK_N-1:0] bank_act_q;
  scd_bank_t        bank_st_ff [BANK_N];
  logic [7:0]       pre_cnt_ff [BANK_N];
  logic [ROW_W-1:0] row_ff     [BANK_N];

  logic             burst_on_ff;
  logic             burst_wr_ff;
  logic [1:0]       burst_bank_ff;
  logic [9:0]       burst_start_ff;
  logic [9:0]       beat_ff;
  logic [9:0]       burst_mask_ff;
  logic             burst_auto_ff;
  logic             burst_page_ff;
  logic             burst_ilv_ff;

  // The level one edge back gates every command; a low level freezes the internal clock.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cke_prev_ff <= 1'b1;
    end else begin
      cke_prev_ff <= cke;
    end
  end

  assign cmd        = cke_prev_ff ? scd_decode(cs_n, ras_n, cas_n, we_n) : CMD_NOP;
  // The bank code carries the low select as its upper bit, as the bank mapping prints it.
  assign sel_bank   = {bank_select_low, bank_select_high};
  assign auto_close = addr[AUTO_CLOSE_BIT];
  assign quiet      = cke_prev_ff && (cmd == CMD_NOP || cmd == CMD_DESEL);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cmd_seen_ff <= 4'h0;
    end else begin
      cmd_seen_ff <= cmd;
    end
  end

  // Mode load takes address and bank selects; other select codes are left unused.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode_reg_ff     <= MODE_RESET;
      ext_mode_reg_ff <= EXT_MODE_RESET;
    end else if (cmd == CMD_MRS) begin
      if ({bank_select_high, bank_select_low} == MR_SEL_BASE) begin
        mode_reg_ff <= addr;
      end else if ({bank_select_high, bank_select_low} == MR_SEL_EXT) begin
        ext_mode_reg_ff <= addr;
      end
    end
  end

  assign cur_mask = scd_burst_mask(mode_reg_ff[MR_BL_LSB +: 3]);
  assign cur_page = (mode_reg_ff[MR_BL_LSB +: 3] == BL_PAGE);
  // A page burst ignores the interleave bit, so it always runs sequentially.
  assign cur_ilv  = mode_reg_ff[MR_BT_BIT] && !cur_page;

  // Per bank state: idle, open, or closing with a recovery count.
  generate
    for (genvar i = 0; i < BANK_N; i++) begin : g_bank
      logic pre_hit;
      logic act_hit;
      logic auto_hit;
      assign bank_ready[i] = (bank_st_ff[i] == BK_IDLE) ||
                             (bank_st_ff[i] == BK_PRECH && pre_cnt_ff[i] == 8'h00);
      assign bank_act_q[i] = (bank_st_ff[i] == BK_ACTIVE);
      assign pre_hit  = (cmd == CMD_PRE) && (auto_close || sel_bank == 2'(i));
      assign act_hit  = (cmd == CMD_ACT) && (sel_bank == 2'(i)) && bank_ready[i];
      assign auto_hit = auto_end && (end_bank == 2'(i));
      assign bank_open[i]        = bank_act_q[i];
      assign bank_precharging[i] = (bank_st_ff[i] == BK_PRECH);

      always_ff @(posedge clk) begin
        if (sys_rst) begin
          bank_st_ff[i] <= BK_IDLE;
          pre_cnt_ff[i] <= 8'h00;
        end else begin
          case (bank_st_ff[i])
            BK_IDLE: begin
              if (act_hit) begin
                bank_st_ff[i] <= BK_ACTIVE;
              end
            end
            BK_ACTIVE: begin
              // Only an open bank reacts; closing or idle banks see a no-operation.
              if (pre_hit || auto_hit) begin
                bank_st_ff[i] <= BK_PRECH;
                pre_cnt_ff[i] <= 8'(PRECHARGE_CYCLES - 1);
              end
            end
            default: begin
              if (pre_cnt_ff[i] == 8'h00) begin
                bank_st_ff[i] <= act_hit ? BK_ACTIVE : BK_IDLE;
              end else begin
                pre_cnt_ff[i] <= pre_cnt_ff[i] - 8'h01;
              end
            end
          endcase
        end
      end

      always_ff @(posedge clk) begin
        if (sys_rst) begin
          row_ff[i] <= '0;
        end else if (act_hit) begin
          row_ff[i] <= addr;
        end
      end
    end
  endgenerate

  assign all_idle = &bank_ready;

  // Burst control. A column command to an open bank restarts at full length, even mid-burst.
  assign col_go    = (cmd == CMD_READ || cmd == CMD_WRITE) && bank_act_q[sel_bank];
  assign stop_now  = (cmd == CMD_BST) ||
                     (cmd == CMD_PRE && (auto_close || sel_bank == burst_bank_ff));
  assign beat_last = !burst_page_ff && (beat_ff == burst_mask_ff);
  assign step      = burst_on_ff && cke_prev_ff && !col_go && !stop_now;
  assign auto_end  = (step && beat_last && burst_auto_ff) ||
                     (col_go && cur_mask == 10'h000 && auto_close);
  assign end_bank  = col_go ? sel_bank : burst_bank_ff;
  assign burst_busy = burst_on_ff;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      burst_on_ff    <= 1'b0;
      burst_wr_ff    <= 1'b0;
      burst_bank_ff  <= 2'h0;
      burst_start_ff <= 10'h000;
      beat_ff        <= 10'h000;
      burst_mask_ff  <= 10'h000;
      burst_auto_ff  <= 1'b0;
      burst_page_ff  <= 1'b0;
      burst_ilv_ff   <= 1'b0;
    end else if (col_go) begin
      burst_on_ff    <= (cur_mask != 10'h000);
      burst_wr_ff    <= (cmd == CMD_WRITE);
      burst_bank_ff  <= sel_bank;
      burst_start_ff <= addr[COL_W-1:0];
      beat_ff        <= 10'h001;
      burst_mask_ff  <= cur_mask;
      burst_auto_ff  <= auto_close;
      burst_page_ff  <= cur_page;
      burst_ilv_ff   <= cur_ilv;
    end else if (stop_now) begin
      burst_on_ff <= 1'b0;
    end else if (step) begin
      beat_ff <= beat_ff + 10'h001;
      if (beat_last) begin
        burst_on_ff <= 1'b0;
      end
    end
  end

  // One access per edge; write mask is sampled in the same edge as its data word.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      access_valid_ff <= 1'b0;
      access_write_ff <= 1'b0;
      access_store_ff <= 1'b0;
      access_bank_ff  <= 2'h0;
      access_col_ff   <= 10'h000;
      access_row_ff   <= '0;
    end else begin
      access_valid_ff <= col_go || step;
      access_write_ff <= col_go ? (cmd == CMD_WRITE) : burst_wr_ff;
      access_store_ff <= (col_go ? (cmd == CMD_WRITE) : (step && burst_wr_ff)) && !dqm;
      access_bank_ff  <= end_bank;
      access_row_ff   <= row_ff[end_bank];
      if (col_go) begin
        access_col_ff <= addr[COL_W-1:0];
      end else begin
        access_col_ff <= scd_beat_col(burst_start_ff, beat_ff, burst_mask_ff,
                                      burst_ilv_ff);
      end
    end
  end

  // Low power entry on a falling enable; a running burst only suspends its clock.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clock_suspend_ff   <= 1'b0;
      power_down_ff      <= 1'b0;
      deep_power_down_ff <= 1'b0;
    end else if (!cke_prev_ff && cke) begin
      clock_suspend_ff   <= 1'b0;
      power_down_ff      <= 1'b0;
      deep_power_down_ff <= 1'b0;
    end else if (cke_prev_ff && !cke) begin
      if (burst_on_ff) begin
        clock_suspend_ff <= 1'b1;
      end else if (cmd == CMD_BST && all_idle) begin
        deep_power_down_ff <= 1'b1;
      end else if (cmd == CMD_NOP || cmd == CMD_DESEL) begin
        power_down_ff <= 1'b1;
      end
    end
  end

  mrs_capture_a: assert property (@(posedge clk) disable iff (sys_rst)
    (cmd == CMD_MRS && {bank_select_high, bank_select_low} == MR_SEL_BASE)
      |=> mode_reg_ff == $past(addr))
    else $error("mode load did not capture the address");

  act_open_a: assert property (@(posedge clk) disable iff (sys_rst)
    (cmd == CMD_ACT && sel_bank == 2'h1 && bank_ready[1])
      |=> bank_open[1] && row_ff[1] == $past(addr))
    else $error("activate did not open bank one with its row");

  pre_all_a: assert property (@(posedge clk) disable iff (sys_rst)
    (cmd == CMD_PRE && auto_close && bank_act_q[2]) |=> bank_precharging[2])
    else $error("precharge all left bank two open");

  pre_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
    (cmd == CMD_PRE && bank_st_ff[0] == BK_IDLE && !(cmd == CMD_ACT))
      |=> !bank_open[0])
    else $error("precharge to an idle bank changed its state");

  col_start_a: assert property (@(posedge clk) disable iff (sys_rst)
    col_go |=> access_valid_ff && access_col_ff == $past(addr[COL_W-1:0]))
    else $error("column command did not present its start column");

  burst_four_a: assert property (@(posedge clk) disable iff (sys_rst)
    (col_go && cur_mask == 10'h003) ##1 (quiet && bank_act_q[burst_bank_ff])[*3]
      |=> !burst_on_ff && access_valid_ff)
    else $error("burst of four did not end after four words");

  store_mask_a: assert property (@(posedge clk) disable iff (sys_rst)
    access_store_ff |-> access_write_ff && !$past(dqm))
    else $error("a masked or read word was stored");

  page_run_a: assert property (@(posedge clk) disable iff (sys_rst)
    (burst_on_ff && burst_page_ff && quiet) |=> burst_on_ff)
    else $error("page burst stopped by itself");

  suspend_a: assert property (@(posedge clk) disable iff (sys_rst)
    (burst_on_ff && cke_prev_ff && !cke) |=> clock_suspend_ff && !power_down_ff)
    else $error("power down entered during a burst");

  frozen_a: assert property (@(posedge clk) disable iff (sys_rst)
    !cke_prev_ff |=> !access_valid_ff)
    else $error("access issued while the internal clock was frozen");

  desel_run_a: assert property (@(posedge clk) disable iff (sys_rst)
    (cmd == CMD_DESEL && burst_on_ff) |=> access_valid_ff)
    else $error("deselect stopped a running burst");

  quiet_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    (cmd == CMD_NOP || cmd == CMD_DESEL)
      |=> mode_reg_ff == $past(mode_reg_ff) && ext_mode_reg_ff == $past(ext_mode_reg_ff))
    else $error("an idle command changed a mode register");

  auto_close_a: assert property (@(posedge clk) disable iff (sys_rst)
    (auto_end && end_bank == 2'h3) |=> bank_precharging[3])
    else $error("auto close left bank three open");

  pre_period_a: assert property (@(posedge clk) disable iff (sys_rst)
    (cmd == CMD_PRE && !auto_close && sel_bank == 2'h2 && bank_act_q[2])
      |-> ##PRECHARGE_CYCLES bank_ready[2])
    else $error("bank two not usable one precharge period after precharge");

  bst_stop_a: assert property (@(posedge clk) disable iff (sys_rst)
    (cmd == CMD_BST && burst_on_ff) |=> !burst_on_ff && !access_valid_ff)
    else $error("burst stop did not end the burst");

endmodule

// ==== core/scd_pkg.sv ====
// Shared constants, types and decode helpers for the DRAM command decoder.
package scd_pkg;

  localparam int ROW_W  = 13;
  localparam int COL_W  = 10;
  localparam int BANK_N = 4;

  // Mode register layout and reset values.
  localparam int          MR_BL_LSB      = 0;
  localparam int          MR_BT_BIT      = 3;
  localparam logic [12:0] MODE_RESET     = 13'h0000;
  localparam logic [12:0] EXT_MODE_RESET = 13'h0000;
  localparam int          AUTO_CLOSE_BIT = 10;

  // Bank select codes, written as {bank_select_high, bank_select_low}.
  localparam logic [1:0] MR_SEL_BASE = 2'h0;
  localparam logic [1:0] MR_SEL_EXT  = 2'h2;

  // Burst length codes.
  localparam logic [2:0] BL_1    = 3'h0;
  localparam logic [2:0] BL_2    = 3'h1;
  localparam logic [2:0] BL_4    = 3'h2;
  localparam logic [2:0] BL_8    = 3'h3;
  localparam logic [2:0] BL_PAGE = 3'h7;

  // Default bank recovery time after precharge, in clock cycles.
  localparam int PRE_CYCLES_DEF = 3;

  typedef enum logic [3:0] {
    CMD_DESEL = 4'h0,
    CMD_NOP   = 4'h1,
    CMD_ACT   = 4'h2,
    CMD_READ  = 4'h3,
    CMD_WRITE = 4'h4,
    CMD_PRE   = 4'h5,
    CMD_MRS   = 4'h6,
    CMD_BST   = 4'h7,
    CMD_REF   = 4'h8
  } scd_cmd_t;

  typedef enum logic [1:0] {
    BK_IDLE   = 2'h0,
    BK_ACTIVE = 2'h1,
    BK_PRECH  = 2'h3
  } scd_bank_t;

  function automatic scd_cmd_t scd_decode(input logic cs_n, input logic ras_n,
                                          input logic cas_n, input logic we_n);
    if (cs_n) begin
      scd_decode = CMD_DESEL;
    end else begin
      case ({ras_n, cas_n, we_n})
        3'h7:    scd_decode = CMD_NOP;
        3'h3:    scd_decode = CMD_ACT;
        3'h5:    scd_decode = CMD_READ;
        3'h4:    scd_decode = CMD_WRITE;
        3'h2:    scd_decode = CMD_PRE;
        3'h0:    scd_decode = CMD_MRS;
        3'h6:    scd_decode = CMD_BST;
        default: scd_decode = CMD_REF;
      endcase
    end
  endfunction

  function automatic logic [9:0] scd_burst_mask(input logic [2:0] bl);
    case (bl)
      BL_2:    scd_burst_mask = 10'h001;
      BL_4:    scd_burst_mask = 10'h003;
      BL_8:    scd_burst_mask = 10'h007;
      BL_PAGE: scd_burst_mask = 10'h3ff;
      default: scd_burst_mask = 10'h000;
    endcase
  endfunction

  function automatic logic [9:0] scd_beat_col(input logic [9:0] start, input logic [9:0] beat,
                                              input logic [9:0] mask, input logic ilv);
    logic [9:0] off;
    off = ilv ? (start ^ beat) : (start + beat);
    scd_beat_col = (start & ~mask) | (off & mask);
  endfunction

endpackage

// ==== tb/scd_ctrl_model.sv ====
// Controller model that issues commands to the decoder pins.
`timescale 1ns/1ps
module scd_ctrl_model
  import scd_pkg::*;
#(
  parameter int MRD_N = 2,
  parameter int RCD_N = 2
) (
  input  wire logic        clk,
  output      logic        cke,
  output      logic        cs_n,
  output      logic        ras_n,
  output      logic        cas_n,
  output      logic        we_n,
  output      logic        dqm,
  output      logic        bank_select_low,
  output      logic        bank_select_high,
  output      logic [12:0] addr
);
  // Precharges go out when called; nothing here waits for bursts or write recovery to end.
  initial begin
    {cke, cs_n, ras_n, cas_n, we_n, dqm} = 6'h3e;
    {bank_select_low, bank_select_high, addr} = 15'h0000;
  end

  task automatic pause(input int n);
    repeat (n - 1) begin
      @(posedge clk);
      {cs_n, ras_n, cas_n, we_n} <= 4'h7;
    end
  endtask

  task automatic send(input scd_cmd_t c, input logic [1:0] bk, input logic [12:0] a,
                      input logic dm);
    logic [2:0] s;
    case (c)
      CMD_ACT:   s = 3'h3;
      CMD_READ:  s = 3'h5;
      CMD_WRITE: s = 3'h4;
      CMD_PRE:   s = 3'h2;
      CMD_MRS:   s = 3'h0;
      CMD_BST:   s = 3'h6;
      default:   s = 3'h7;
    endcase
    @(posedge clk);
    cs_n <= (c == CMD_DESEL);
    // Strobes float while deselected, so they must not keep their last level.
    {ras_n, cas_n, we_n} <= (c == CMD_DESEL) ? ~{ras_n, cas_n, we_n} : s;
    // Mode loads give their select code high select first; other commands give a bank index.
    if (c == CMD_MRS) begin
      {bank_select_high, bank_select_low} <= bk;
    end else begin
      {bank_select_low, bank_select_high} <= bk;
    end
    addr <= a;
    dqm <= dm;
    if (c == CMD_MRS) pause(MRD_N);
    if (c == CMD_ACT) pause(RCD_N);
  endtask

  task automatic set_cke(input logic v);
    @(posedge clk);
    cke <= v;
  endtask
endmodule

// ==== tb/scd_decoder_tb.sv ====
// Testbench for the DRAM command decoder, driven through the controller model.
`timescale 1ns/1ps
module scd_decoder_tb
  import scd_pkg::*;
;
  localparam int PRE_N = 2;
  logic              clk = 1'b0;
  logic              sys_rst = 1'b1;
  logic              cke;
  logic              cs_n;
  logic              ras_n;
  logic              cas_n;
  logic              we_n;
  logic              dqm;
  logic              bsl;
  logic              bsh;
  logic [12:0]       addr;
  logic [12:0]       mode_reg_ff;
  logic [12:0]       ext_mode_reg_ff;
  logic [BANK_N-1:0] bank_open;
  logic [BANK_N-1:0] bank_precharging;
  logic              burst_busy;
  logic              access_valid_ff;
  logic              access_write_ff;
  logic              access_store_ff;
  logic [1:0]        access_bank_ff;
  logic [COL_W-1:0]  access_col_ff;
  logic [ROW_W-1:0]  access_row_ff;
  logic              clock_suspend_ff;
  logic              power_down_ff;
  logic              deep_power_down_ff;
  logic [12:0]       cur_row;
  logic [3:0]        cmd_seen;
  int                n_mismatch = 0;
  int                cmp_count = 0;

  always #2 clk = ~clk;

  scd_ctrl_model scd_ctrl_model_inst (
    .clk(clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .dqm(dqm), .bank_select_low(bsl), .bank_select_high(bsh), .addr(addr)
  );

  scd_decoder #(.PRECHARGE_CYCLES(PRE_N)) scd_decoder_inst (
    .clk(clk), .sys_rst(sys_rst), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .dqm(dqm), .bank_select_low(bsl), .bank_select_high(bsh), .addr(addr),
    .cmd_seen_ff(cmd_seen), .mode_reg_ff(mode_reg_ff), .ext_mode_reg_ff(ext_mode_reg_ff),
    .bank_open(bank_open), .bank_precharging(bank_precharging), .burst_busy(burst_busy),
    .access_valid_ff(access_valid_ff), .access_write_ff(access_write_ff),
    .access_store_ff(access_store_ff), .access_bank_ff(access_bank_ff),
    .access_col_ff(access_col_ff), .access_row_ff(access_row_ff),
    .clock_suspend_ff(clock_suspend_ff), .power_down_ff(power_down_ff),
    .deep_power_down_ff(deep_power_down_ff)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic send(input scd_cmd_t c, input logic [1:0] bk = 2'h0,
                      input logic [12:0] a = 13'h0000, input logic dm = 1'b0);
    scd_ctrl_model_inst.send(c, bk, a, dm);
  endtask

  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic burst(input logic [9:0] st, input int n, input logic [9:0] m,
                       input logic ilv, input logic wr, input logic [9:0] pat,
                       input logic [1:0] bk, input logic endv);
    logic [9:0] o;
    // Each pass shows the word launched at the edge just passed, the first one by the command.
    for (int i = 0; i < n; i++) begin
      send(i == 0 ? CMD_DESEL : CMD_NOP, bk, 13'h0000, pat[i+1]);
      #1;
      o = ilv ? (st ^ 10'(i)) : (st + 10'(i));
      chk(access_valid_ff, 1'b1);
      chk(access_col_ff, (st & ~m) | (o & m));
      chk({access_bank_ff, access_row_ff}, {bk, cur_row});
      chk({access_write_ff, access_store_ff}, {wr, wr & ~pat[i]});
      chk(burst_busy, endv | (i < n - 1));
    end
    send(CMD_NOP);
    #1;
    chk(access_valid_ff, endv);
  endtask

  task automatic test_mode_load;
    send(CMD_MRS, MR_SEL_BASE, 13'h000b);
    send(CMD_MRS, MR_SEL_EXT, 13'h0015);
    send(CMD_MRS, 2'h1, 13'h1fff);
    tick();
    chk({mode_reg_ff, ext_mode_reg_ff}, {13'h000b, 13'h0015});
    $display("test mode load done");
  endtask

  task automatic test_interleaved_read;
    cur_row = 13'h1abc;
    send(CMD_ACT, 2'h2, cur_row);
    send(CMD_DESEL);
    send(CMD_NOP);
    tick();
    chk(bank_open, 4'h4);
    send(CMD_READ, 2'h2, 13'h003a);
    burst(10'h03a, 8, 10'h007, 1'b1, 1'b0, 10'h000, 2'h2, 1'b0);
    chk(bank_open, 4'h4);
    $display("test interleaved read done");
  endtask

  task automatic test_precharge;
    send(CMD_PRE, 2'h1, 13'h0000);
    send(CMD_NOP);
    tick();
    chk({bank_open, bank_precharging}, 8'h40);
    // The open row is closed before the bank is activated again on the same row.
    send(CMD_PRE, 2'h2, 13'h0000);
    tick();
    chk({bank_open, bank_precharging}, 8'h04);
    chk(cmd_seen, CMD_PRE);
    send(CMD_ACT, 2'h2, cur_row);
    tick();
    chk(bank_open, 4'h4);
    send(CMD_ACT, 2'h0, 13'h0011);
    send(CMD_ACT, 2'h3, 13'h0022);
    send(CMD_PRE, 2'h1, 13'h0400);
    send(CMD_NOP);
    tick();
    chk(bank_open, 4'h0);
    $display("test precharge done");
  endtask

  task automatic test_page_burst;
    tick(2);
    send(CMD_MRS, MR_SEL_BASE, 13'h0007);
    cur_row = 13'h0777;
    send(CMD_ACT, 2'h1, cur_row);
    send(CMD_READ, 2'h1, 13'h03fe);
    burst(10'h3fe, 6, 10'h3ff, 1'b0, 1'b0, 10'h000, 2'h1, 1'b1);
    send(CMD_BST);
    send(CMD_NOP);
    tick();
    chk({access_valid_ff, burst_busy}, 2'h0);
    $display("test page burst done");
  endtask

  task automatic test_interrupt_write;
    send(CMD_PRE, 2'h0, 13'h0400);
    send(CMD_NOP);
    tick(2);
    send(CMD_MRS, MR_SEL_BASE, 13'h0002);
    cur_row = 13'h0abc;
    send(CMD_ACT, 2'h3, cur_row);
    send(CMD_READ, 2'h3, 13'h0000);
    send(CMD_READ, 2'h3, 13'h0008);
    burst(10'h008, 4, 10'h003, 1'b0, 1'b0, 10'h000, 2'h3, 1'b0);
    send(CMD_WRITE, 2'h3, 13'h0405);
    burst(10'h005, 4, 10'h003, 1'b0, 1'b1, 10'h00a, 2'h3, 1'b0);
    chk(bank_open, 4'h0);
    $display("test interrupt and write done");
  endtask

  task automatic test_low_power;
    tick(3);
    scd_ctrl_model_inst.set_cke(1'b0);
    tick(2);
    chk(power_down_ff, 1'b1);
    send(CMD_ACT, 2'h0, 13'h0001);
    #1;
    chk(cmd_seen, CMD_NOP);
    scd_ctrl_model_inst.set_cke(1'b1);
    tick(3);
    chk({power_down_ff, bank_open}, 5'h00);
    send(CMD_BST);
    scd_ctrl_model_inst.set_cke(1'b0);
    tick(2);
    chk(deep_power_down_ff, 1'b1);
    send(CMD_NOP);
    scd_ctrl_model_inst.set_cke(1'b1);
    tick(3);
    chk(deep_power_down_ff, 1'b0);
    send(CMD_MRS, MR_SEL_BASE, 13'h0002);
    send(CMD_ACT, 2'h0, 13'h0100);
    send(CMD_READ, 2'h0, 13'h0000);
    send(CMD_NOP);
    scd_ctrl_model_inst.set_cke(1'b0);
    tick(2);
    chk({clock_suspend_ff, power_down_ff}, 2'h2);
    scd_ctrl_model_inst.set_cke(1'b1);
    tick(3);
    $display("test low power done");
  endtask

  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    test_mode_load();
    test_interleaved_read();
    test_precharge();
    test_page_burst();
    test_interrupt_write();
    test_low_power();
    tally_and_finish;
  end

  // The whole sequence takes well under a thousand cycles, so this leaves wide margin.
  initial begin
    #20000;
    n_mismatch++;
    tally_and_finish;
  end
endmodule
